// [core/ncc_cmd_dev.sv]
// command register logic of the network controller
`timescale 1ns/100ps
module ncc_cmd_dev (
  input  wire logic       i_clk,          // system clock
  input  wire logic       i_rst,          // sync reset, high
  input  wire logic       i_ce,           // clock enable
  ncc_if.dev              bus,            // register port
  input  wire logic       i_rx_busy,      // reception under way
  input  wire logic       i_tx_busy,      // transmission under way
  input  wire logic       i_tx_done,      // send completed or aborted
  input  wire logic       i_rbc_zero,     // remote count is zero
  input  wire logic       i_rbc_reload,   // remote count rewritten
  input  wire logic       i_read_ack,     // read acknowledge
  input  wire logic       i_write_ack,    // write acknowledge
  input  wire logic       i_rst_flag_clr, // clear reset-done flag
  output logic            o_online,       // controller running
  output logic [2:0]      o_page,         // one-hot page select
  output logic            o_tx_start,     // transmit start pulse
  output logic            o_tx_pending,   // transmit bit state
  output logic            o_rst_done,     // reset-done flag
  output logic            o_rdma_active,  // remote transfer on
  output logic [1:0]      o_rdma_op,      // remote transfer kind
  output logic            o_rdma_start,   // remote start pulse
  output logic            o_rdma_abort,   // remote stop pulse
  output logic            o_rdma_done,    // remote done pulse
  output logic            o_port_request  // port request
);
  // operating modes
  typedef enum logic [1:0] {
    M_STOPPED,
    M_RUN,
    M_DRAIN
  } ncc_mode_e;

  ncc_mode_e  mode_q;     // current mode
  ncc_mode_e  mode_d;     // next mode
  logic       halt_q;     // halt bit
  logic       run_q;      // run bit
  logic       txgo_q;     // transmit request bit
  logic [1:0] page_q;     // page select bits
  logic [2:0] rcmd_q;     // remote command field
  logic       reload_q;   // count rewritten since start
  logic       wr_cmd;     // write to the command register
  logic [7:0] wd;         // write data alias
  logic [2:0] wfield;     // written remote field
  logic       tx_set;     // accepted transmit request
  logic       r_start;    // start remote transfer
  logic       r_abort;    // abort remote transfer
  logic       r_finish;   // stale reissue ends transfer
  logic       r_done;     // count-zero completion

  assign wr_cmd = bus.wr && (bus.addr == ncc_pkg::CMD_OFS);
  assign wd     = bus.wdata;
  assign wfield = wd[ncc_pkg::RDMA_LSB +: 3];

  // mode sequencing
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      M_STOPPED:
        // leave halt only when halt clear and run set
        if (wr_cmd && !wd[ncc_pkg::HALT_BIT] && wd[ncc_pkg::RUN_BIT])
          mode_d = M_RUN;
      M_RUN:
        // halt asks for a software reset
        if (wr_cmd && wd[ncc_pkg::HALT_BIT])
          mode_d = M_DRAIN;
      M_DRAIN:
        if (!i_rx_busy && !i_tx_busy)
          mode_d = M_STOPPED;
      default:
        mode_d = M_STOPPED;
    endcase
  end

  // mode register and online output
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      mode_q   <= M_STOPPED;
      o_online <= 1'b0;
    end
    else if (i_ce)
    begin
      mode_q   <= mode_d;
      // offline as soon as halt is taken
      o_online <= (mode_d == M_RUN);
    end
  end

  // reset-done flag; a new completion beats a clear
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rst_done <= 1'b1;
    else if (i_ce)
    begin
      // the only sign that reset took effect
      if (mode_q != M_STOPPED && mode_d == M_STOPPED)
        o_rst_done <= 1'b1;
      else if (i_rst_flag_clr)
        o_rst_done <= 1'b0;
    end
  end

  // halt and run bits
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      halt_q <= ncc_pkg::CMD_RST[ncc_pkg::HALT_BIT];
      run_q  <= ncc_pkg::CMD_RST[ncc_pkg::RUN_BIT];
    end
    else if (i_ce && wr_cmd)
    begin
      halt_q <= wd[ncc_pkg::HALT_BIT];
      // run stays set when halted from running
      run_q  <= wd[ncc_pkg::RUN_BIT] ||
                (wd[ncc_pkg::HALT_BIT] && mode_q == M_RUN);
    end
  end

  // new packets only while running and not halting now
  assign tx_set = wr_cmd && wd[ncc_pkg::TXGO_BIT] &&
                  !wd[ncc_pkg::HALT_BIT] && mode_q == M_RUN;

  // transmit request bit
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      txgo_q     <= ncc_pkg::CMD_RST[ncc_pkg::TXGO_BIT];
      o_tx_start <= 1'b0;
    end
    else if (i_ce)
    begin
      // start once, self-clear on done or abort
      o_tx_start <= tx_set && !txgo_q;
      if (tx_set)
        txgo_q <= 1'b1;
      else if (i_tx_done)
        txgo_q <= 1'b0;
      // a zero transmit bit leaves it alone
    end
  end

  assign o_tx_pending = txgo_q;

  // remote command decode
  // abort codes, transfer codes
  assign r_abort  = wr_cmd && wfield[2];
  // code zero never starts; busy blocks start
  assign r_start  = wr_cmd && ncc_pkg::is_op(wfield) && !o_rdma_active;
  // reissue with transmit and no reload ends it
  assign r_finish = wr_cmd && o_rdma_active && wd[ncc_pkg::TXGO_BIT] &&
                    wfield == rcmd_q && !reload_q;

  // remote command field readback
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rcmd_q <= ncc_pkg::CMD_RST[ncc_pkg::RDMA_LSB +: 3];
    else if (i_ce)
    begin
      if (r_abort || r_start)
        rcmd_q <= wfield;
      else if (r_finish || r_done)
        rcmd_q <= ncc_pkg::RDMA_END;
      // same code rewritten keeps the field, except a reissue that ends it
    end
  end

  // track byte count rewrites since the last start
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      reload_q <= 1'b0;
    else if (i_ce)
    begin
      if (i_rbc_reload)
        reload_q <= 1'b1;
      else if (r_start)
        reload_q <= 1'b0;
    end
  end

  // remote transfer tracker
  ncc_rdma_ctl u_rdma (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_start     (r_start),
    .i_op        (wfield[1:0]),
    .i_stop      (r_abort || r_finish),
    .i_rbc_zero  (i_rbc_zero),
    .i_read_ack  (i_read_ack),
    .i_write_ack (i_write_ack),
    .o_active    (o_rdma_active),
    .o_op        (o_rdma_op),
    .o_start     (o_rdma_start),
    .o_abort     (o_rdma_abort),
    .o_done      (o_rdma_done),
    .o_port_req  (o_port_request)
  );

  // completion as seen by the field logic, one cycle early
  assign r_done = o_rdma_active && i_rbc_zero && !r_abort && !r_finish;

  // page select; reserved code stored but selects nothing
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      page_q <= ncc_pkg::CMD_RST[ncc_pkg::PAGE_LSB +: 2];
      o_page <= ncc_pkg::page_hot(ncc_pkg::CMD_RST[ncc_pkg::PAGE_LSB +: 2]);
    end
    else if (i_ce && wr_cmd)
    begin
      // top bits steer the address lines
      page_q <= wd[ncc_pkg::PAGE_LSB +: 2];
      o_page <= ncc_pkg::page_hot(wd[ncc_pkg::PAGE_LSB +: 2]);
    end
  end

  // read port; other addresses belong to other blocks
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      bus.rvalid <= 1'b0;
      bus.rdata  <= 8'h00;
    end
    else if (i_ce)
    begin
      bus.rvalid <= bus.rd;
      if (bus.rd && bus.addr == ncc_pkg::CMD_OFS)
        bus.rdata <= {page_q, rcmd_q, txgo_q, run_q, halt_q};
      else if (bus.rd)
        bus.rdata <= 8'h00;
    end
  end
endmodule

// [core/ncc_pkg.sv]
// shared constants for the command register ends
package ncc_pkg;
  // command register location within every page
  localparam logic [3:0] CMD_OFS   = 4'h0;
  // command register field positions
  localparam int         HALT_BIT  = 0;
  localparam int         RUN_BIT   = 1;
  localparam int         TXGO_BIT  = 2;
  localparam int         RDMA_LSB  = 3;
  localparam int         PAGE_LSB  = 6;
  // power-up value: halted, idle remote channel
  localparam logic [7:0] CMD_RST   = 8'h21;
  // remote command codes
  localparam logic [2:0] RDMA_BAD  = 3'h0;
  localparam logic [2:0] RDMA_READ = 3'h1;
  localparam logic [2:0] RDMA_WRT  = 3'h2;
  localparam logic [2:0] RDMA_SEND = 3'h3;
  localparam logic [2:0] RDMA_END  = 3'h4;
  // page codes
  localparam logic [1:0] PAGE_RSVD = 2'h3;
  // controller register byte offsets on the host bus
  localparam logic [7:0] HOFS_DATA = 8'h00;
  localparam logic [7:0] HOFS_ADDR = 8'h04;
  localparam logic [7:0] HOFS_GO   = 8'h08;
  localparam logic [7:0] HOFS_STAT = 8'h0c;
  // order register bits
  localparam int         GO_WR     = 0;
  localparam int         GO_RD     = 1;
  localparam int         GO_MERGE  = 2;
  localparam int         GO_RESUME = 3;

  // one-hot page decode; reserved page selects nothing
  function automatic logic [2:0] page_hot(input logic [1:0] p);
    page_hot = (p == PAGE_RSVD) ? 3'h0 : 3'(3'h1 << p);
  endfunction

  // true for a command that starts a transfer
  function automatic logic is_op(input logic [2:0] c);
    is_op = (c != RDMA_BAD) && !c[2];
  endfunction
endpackage

// [core/ncc_if.sv]
// register port between host end and device end
`timescale 1ns/100ps
interface ncc_if;
  logic       wr;     // write strobe, one cycle
  logic       rd;     // read strobe, one cycle
  logic [3:0] addr;   // register address lines
  logic [7:0] wdata;  // write data
  logic [7:0] rdata;  // read data
  logic       rvalid; // read data valid, one cycle

  modport dev  (input wr, rd, addr, wdata, output rdata, rvalid);
  modport host (output wr, rd, addr, wdata, input rdata, rvalid);
endinterface

// [core/ncc_rdma_ctl.sv]
// remote transfer tracker with port request handling
`timescale 1ns/100ps
module ncc_rdma_ctl (
  input  wire logic       i_clk,      // system clock
  input  wire logic       i_rst,      // sync reset, high
  input  wire logic       i_ce,       // clock enable
  input  wire logic       i_start,    // begin transfer
  input  wire logic [1:0] i_op,       // transfer kind
  input  wire logic       i_stop,     // abort or force end
  input  wire logic       i_rbc_zero, // byte count reached zero
  input  wire logic       i_read_ack, // read acknowledge
  input  wire logic       i_write_ack,// write acknowledge
  output logic            o_active,   // transfer running
  output logic [1:0]      o_op,       // kind of transfer
  output logic            o_start,    // start pulse
  output logic            o_abort,    // stop pulse
  output logic            o_done,     // count-zero end pulse
  output logic            o_port_req  // port request
);
  // activity and kind
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_active <= 1'b0;
      o_op     <= 2'h0;
    end
    else if (i_ce)
    begin
      if (i_start)
      begin
        o_active <= 1'b1;
        o_op     <= i_op;
      end
      else if (i_stop || (o_active && i_rbc_zero))
        o_active <= 1'b0;
    end
  end

  // event pulses; address reload is cued by start alone
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_start <= 1'b0;
      o_abort <= 1'b0;
      o_done  <= 1'b0;
    end
    else if (i_ce)
    begin
      o_start <= i_start;
      o_abort <= i_stop && o_active;
      o_done  <= o_active && i_rbc_zero && !i_stop;
    end
  end

  // request lingers after an early abort until acknowledged
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_port_req <= 1'b0;
    else if (i_ce)
    begin
      if (i_start)
        o_port_req <= 1'b1;
      else if (i_rbc_zero)
        o_port_req <= 1'b0;
      else if (!o_active && (i_read_ack || i_write_ack))
        o_port_req <= 1'b0;
    end
  end
endmodule

// [core/ncc_cmd_host.sv]
// host end: bus-driven sequencer for the register port
`timescale 1ns/100ps
module ncc_cmd_host (
  input  wire logic        i_clk,       // system clock
  input  wire logic        i_rst,       // sync reset, high
  input  wire logic        i_ce,        // clock enable
  input  wire logic        i_hsel,      // slave select
  input  wire logic [31:0] i_haddr,     // address
  input  wire logic [1:0]  i_htrans,    // transfer type
  input  wire logic        i_hwrite,    // write
  input  wire logic [2:0]  i_hsize,     // size, word only
  input  wire logic [31:0] i_hwdata,    // write data
  input  wire logic        i_hready,    // bus ready
  output logic             o_hreadyout, // slave ready
  output logic [31:0]      o_hrdata,    // read data
  output logic             o_hresp,     // response, okay
  ncc_if.host              bus          // register port
);
  logic       ap_q;    // write data phase pending
  logic [7:0] ap_ofs;  // captured offset
  logic [7:0] data_q;  // byte to send
  logic [3:0] addr_q;  // target address
  logic       busy_q;  // read awaiting data
  logic       refd_q;  // sticky refused flag
  logic [7:0] last_q;  // last read byte
  logic [2:0] shad_q;  // remote field last sent or read
  logic [7:0] out_b;   // byte after merge
  logic       refuse;  // order would break sequencing
  logic       go;      // order write in data phase
  logic [31:0] wdat;   // write data alias

  assign wdat = i_hwdata;
  assign go   = ap_q && ap_ofs == ncc_pkg::HOFS_GO && !busy_q;

  // compose the byte for a command register write
  always_comb
  begin
    out_b = data_q;
    // keep the active remote code with transmit
    if (wdat[ncc_pkg::GO_MERGE] && data_q[ncc_pkg::TXGO_BIT] &&
        ncc_pkg::is_op(shad_q))
      out_b[ncc_pkg::RDMA_LSB +: 3] = shad_q;
    // resume means halt clear and run set
    if (wdat[ncc_pkg::GO_RESUME])
    begin
      out_b[ncc_pkg::HALT_BIT] = 1'b0;
      out_b[ncc_pkg::RUN_BIT]  = 1'b1;
    end
  end

  // no read over write; write needs read or write code
  assign refuse = addr_q == ncc_pkg::CMD_OFS &&
    ((out_b[ncc_pkg::RDMA_LSB +: 3] == ncc_pkg::RDMA_WRT &&
      shad_q != ncc_pkg::RDMA_READ && shad_q != ncc_pkg::RDMA_WRT) ||
     (out_b[ncc_pkg::RDMA_LSB +: 3] == ncc_pkg::RDMA_READ &&
      shad_q == ncc_pkg::RDMA_WRT));

  // bus address phase capture and fixed answer
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ap_q        <= 1'b0;
      ap_ofs      <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      o_hrdata    <= 32'h0;
    end
    else if (i_ce)
    begin
      ap_q   <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
      ap_ofs <= i_haddr[7:0];
      // read data prepared during the address phase
      if (i_hsel && i_htrans[1] && i_hready && !i_hwrite)
        case (i_haddr[7:0])
          ncc_pkg::HOFS_DATA: o_hrdata <= {24'h0, data_q};
          ncc_pkg::HOFS_ADDR: o_hrdata <= {28'h0, addr_q};
          ncc_pkg::HOFS_STAT: o_hrdata <= {16'h0, last_q, 6'h0,
                                           refd_q, busy_q};
          default:            o_hrdata <= 32'h0;
        endcase
    end
  end

  // order registers and strobes to the device
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      data_q    <= 8'h00;
      addr_q    <= 4'h0;
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      bus.addr  <= 4'h0;
      bus.wdata <= 8'h00;
      shad_q    <= ncc_pkg::CMD_RST[ncc_pkg::RDMA_LSB +: 3];
    end
    else if (i_ce)
    begin
      bus.wr <= go && wdat[ncc_pkg::GO_WR] && !refuse;
      bus.rd <= go && wdat[ncc_pkg::GO_RD] && !wdat[ncc_pkg::GO_WR];
      if (ap_q && ap_ofs == ncc_pkg::HOFS_DATA)
        data_q <= wdat[7:0];
      if (ap_q && ap_ofs == ncc_pkg::HOFS_ADDR)
        addr_q <= wdat[3:0];
      if (go)
      begin
        bus.addr  <= addr_q;
        bus.wdata <= out_b;
      end
      if (go && wdat[ncc_pkg::GO_WR] && !refuse &&
          addr_q == ncc_pkg::CMD_OFS &&
          out_b[ncc_pkg::RDMA_LSB +: 3] != ncc_pkg::RDMA_BAD)
        shad_q <= out_b[ncc_pkg::RDMA_LSB +: 3];
      else if (bus.rvalid && bus.addr == ncc_pkg::CMD_OFS)
        shad_q <= bus.rdata[ncc_pkg::RDMA_LSB +: 3];
    end
  end

  // status: read wait, refusal, returned byte
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      busy_q <= 1'b0;
      refd_q <= 1'b0;
      last_q <= 8'h00;
    end
    else if (i_ce)
    begin
      if (go && wdat[ncc_pkg::GO_RD] && !wdat[ncc_pkg::GO_WR])
        busy_q <= 1'b1;
      else if (bus.rvalid)
        busy_q <= 1'b0;
      if (bus.rvalid)
        last_q <= bus.rdata;
      // a new refusal beats the clear
      if (go && wdat[ncc_pkg::GO_WR] && refuse)
        refd_q <= 1'b1;
      else if (ap_q && ap_ofs == ncc_pkg::HOFS_STAT && wdat[1])
        refd_q <= 1'b0;
    end
  end
endmodule

// [sim/ncc_link_asserts.sv]
// protocol checker for the register port between the two ends
`timescale 1ns/100ps
module ncc_link_asserts (
  input wire logic       i_clk,  // system clock
  input wire logic       i_rst,  // sync reset, high
  input wire logic       wr,     // write strobe
  input wire logic       rd,     // read strobe
  input wire logic [3:0] addr,   // register address lines
  input wire logic [7:0] wdata,  // write byte
  input wire logic [7:0] rdata,  // read byte
  input wire logic       rvalid  // read data valid
);
  logic       rd_cmd_q;  // command read issued last cycle
  logic       wr_seen_q; // command written since reset
  logic [1:0] page_q;    // last page code written

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // follow command accesses so readbacks can be judged
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rd_cmd_q  <= 1'b0;
      wr_seen_q <= 1'b0;
      page_q    <= ncc_pkg::CMD_RST[7:6];
    end
    else
    begin
      rd_cmd_q <= rd && (addr == ncc_pkg::CMD_OFS);
      // only real strobes count, refused orders never reach the port
      if (wr && (addr == ncc_pkg::CMD_OFS))
      begin
        wr_seen_q <= 1'b1;
        page_q    <= wdata[7:6];
      end
    end
  end

  // a command read and its answer
  sequence s_cmd_rd;
    rd && (addr == ncc_pkg::CMD_OFS);
  endsequence
  sequence s_answer;
    ##1 rvalid;
  endsequence

  AST_RD_ANSWER: assert property (s_cmd_rd |-> s_answer)
    else $error("command read not answered one cycle later");
  AST_RVALID_CAUSE: assert property (rvalid |-> $past(rd))
    else $error("read valid without a read strobe");
  AST_WR_PULSE: assert property (wr |=> !wr)
    else $error("write strobe longer than one cycle");
  AST_RD_PULSE: assert property (rd |=> !rd)
    else $error("read strobe longer than one cycle");
  AST_NO_BOTH: assert property (!(wr && rd))
    else $error("read and write strobes together");
  AST_RDATA_HOLD: assert property (!$past(rd) |-> $stable(rdata))
    else $error("read byte changed without a read");
  AST_IDLE_AFTER_RST: assert property ($past(i_rst) |-> !wr && !rd)
    else $error("strobe right after reset");
  AST_RESET_VALUE: assert property (rvalid && rd_cmd_q && !wr_seen_q
    |-> rdata == ncc_pkg::CMD_RST)
    else $error("command power-up value wrong");
  AST_PAGE_KEEP: assert property (rvalid && rd_cmd_q
    |-> rdata[7:6] == page_q)
    else $error("page bits differ from last written");
endmodule

// [sim/testbench.sv]
// self-checking bench for the host and device ends of the command port
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0;          // system clock
  logic        rst = 1'b1;          // sync reset
  logic        hsel = 1'b0;         // slave select
  logic [1:0]  htrans = 2'h0;       // transfer type
  logic [31:0] haddr = 32'h0;       // bus address
  logic        hwrite = 1'b0;       // write direction
  logic [31:0] hwdata = 32'h0;      // write word
  logic [31:0] hrdata;              // read word
  logic        hreadyout;           // slave ready, also bus ready
  logic        hresp;               // response
  logic [7:0]  din = 8'h0;          // device side inputs
  wire  [9:0]  po;                  // packed level outputs
  wire  [3:0]  ev;                  // tx, start, abort, done pulses
  int          n_ev[4] = '{4{0}};   // pulses seen
  int          x_ev[4] = '{4{0}};   // pulses expected
  int          m_page = 0;          // model page code
  int          m_field = 4;         // model remote field
  int          m_tx = 0;            // model transmit bit
  int          m_run = 0;           // model run bit
  int          m_halt = 1;          // model halt bit
  int          m_on = 0;            // model online
  int          m_rdone = 1;         // model reset-done flag
  int          m_op = 0;            // model remote kind, 0 idle
  int          m_preq = 0;          // model port request
  int          failures = 0;        // mismatches
  int          checks = 0;          // comparisons
  logic [31:0] seed = 32'hd5b199ee; // random state
  logic [31:0] r;                   // last bus read

  ncc_if link ();
  ncc_cmd_host ncc_cmd_host_inst (
    .i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hreadyout(hreadyout), .o_hrdata(hrdata), .o_hresp(hresp),
    .bus(link.host));
  ncc_cmd_dev ncc_cmd_dev_inst (
    .i_clk(clk), .i_rst(rst), .i_ce(1'b1), .bus(link.dev),
    .i_rx_busy(din[0]), .i_tx_busy(din[1]), .i_tx_done(din[2]),
    .i_rbc_zero(din[3]), .i_rbc_reload(din[4]), .i_read_ack(din[5]),
    .i_write_ack(din[6]), .i_rst_flag_clr(din[7]), .o_online(po[0]),
    .o_page(po[9:7]), .o_tx_start(ev[0]), .o_tx_pending(po[1]),
    .o_rst_done(po[2]), .o_rdma_active(po[3]), .o_rdma_op(po[6:5]),
    .o_rdma_start(ev[1]), .o_rdma_abort(ev[2]), .o_rdma_done(ev[3]),
    .o_port_request(po[4]));
  ncc_link_asserts ncc_link_asserts_inst (
    .i_clk(clk), .i_rst(rst), .wr(link.wr), .rd(link.rd),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .rvalid(link.rvalid));

  // free-running clock, 5 ns period
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // count pulses so short outputs are never missed
  always @(posedge clk)
    for (int i = 0; i < 4; i++)
      n_ev[i] += (ev[i] === 1'b1);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // command byte the model expects on readback
  function automatic logic [7:0] mcmd();
    return {2'(m_page), 3'(m_field), 1'(m_tx), 1'(m_run), 1'(m_halt)};
  endfunction

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
    chk_reg(g, e);
  endtask

  // one single-word transfer; waits on ready, never on a fixed count
  task automatic ahb(input bit w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic poke(input int b, input logic x);
    @(posedge clk);
    din[b] <= x;
  endtask

  task automatic pulse(input int b);
    poke(b, 1'b1);
    poke(b, 1'b0);
  endtask

  // data byte, then a write order with the given order bits
  task automatic cmd_wr(input int p, f, t, ru, h, input logic [3:0] go);
    ahb(1'b1, 8'h00, {24'h0, 2'(p), 3'(f), 1'(t), 1'(ru), 1'(h)});
    ahb(1'b1, 8'h08, {28'h0, go});
  endtask

  // read order, poll until idle, compare the byte with the model
  task automatic rd_chk();
    ahb(1'b1, 8'h08, 32'h2);
    for (int k = 0; k < 20; k++)
    begin
      ahb(1'b0, 8'h0c, 32'h0);
      if (r[0] === 1'b0)
        break;
    end
    chk_reg(r[15:8], mcmd());
  endtask

  // settle, then compare every level output and the pulse counts
  task automatic check_pins();
    logic [10:0] e;
    repeat (5) @(posedge clk);
    e = {1'b0, (m_page == 3) ? 3'h0 : 3'(3'h1 << m_page), 2'(m_op),
         m_preq != 0, m_op != 0, m_rdone != 0, m_tx != 0, m_on != 0};
    chk_pin({hresp, po[9:7], po[6:5] & {2{po[3]}}, po[4:0]}, e);
    for (int i = 0; i < 4; i++)
      chk_pin(n_ev[i], x_ev[i]);
  endtask

  task automatic final_report();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // cut a hang short well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk();
    check_pins();
    // every page code with random abort codes while idle
    for (int p = 0; p < 4; p++)
    begin
      seed = xs(seed);
      m_page = p;
      m_field = 4 + int'(seed[1:0]);
      cmd_wr(p, m_field, 0, 0, 1, 4'h1);
      check_pins();
      rd_chk();
    end
    pulse(7);
    m_rdone = 0;
    m_page = 0;
    m_field = 4;
    cmd_wr(0, 4, 0, 1, 0, 4'h1);
    m_run = 1;
    m_halt = 0;
    m_on = 1;
    check_pins();
    cmd_wr(0, 4, 1, 1, 0, 4'h1);
    m_tx = 1;
    x_ev[0]++;
    check_pins();
    cmd_wr(0, 4, 0, 1, 0, 4'h1);
    check_pins();
    rd_chk();
    pulse(2);
    m_tx = 0;
    check_pins();
    // read started, code zero ignored, abort with count left
    cmd_wr(0, 1, 0, 1, 0, 4'h1);
    m_op = 1;
    m_preq = 1;
    x_ev[1]++;
    check_pins();
    cmd_wr(0, 0, 0, 1, 0, 4'h1);
    check_pins();
    cmd_wr(0, 4, 0, 1, 0, 4'h1);
    m_op = 0;
    x_ev[2]++;
    check_pins();
    pulse(5);
    m_preq = 0;
    check_pins();
    pulse(4);
    // write code without priming is held back by the host end
    cmd_wr(0, 2, 0, 1, 0, 4'h1);
    check_pins();
    ahb(1'b0, 8'h0c, 32'h0);
    chk_reg(r[1], 1'b1);
    ahb(1'b1, 8'h0c, 32'h2);
    // read, write, send in turn; the first two end at count zero
    for (int c = 1; c < 4; c++)
    begin
      cmd_wr(0, c, 0, 1, 0, 4'h1);
      m_op = c;
      m_preq = 1;
      x_ev[1]++;
      check_pins();
      if (c == 2)
      begin
        // read over running write held back
        cmd_wr(0, 1, 0, 1, 0, 4'h1);
        check_pins();
        ahb(1'b0, 8'h0c, 32'h0);
        chk_reg(r[1], 1'b1);
        ahb(1'b1, 8'h0c, 32'h2);
      end
      if (c < 3)
      begin
        poke(3, 1'b1);
        m_op = 0;
        m_preq = 0;
        x_ev[3]++;
        check_pins();
        poke(3, 1'b0);
      end
    end
    // merged reissue with transmit ends the send at once
    cmd_wr(0, 0, 1, 1, 0, 4'h5);
    // transmit start, and the ended send shows as an abort pulse
    x_ev[0]++;
    x_ev[2]++;
    pulse(6);
    m_op = 0;
    m_preq = 0;
    m_tx = 1;
    check_pins();
    rd_chk();
    pulse(2);
    m_tx = 0;
    // halt while traffic runs: reset-done held low during the drain, offline and reset-done checked after it
    poke(1, 1'b1);
    cmd_wr(0, 4, 0, 1, 1, 4'h1);
    m_halt = 1;
    rd_chk();
    chk_pin(po[2], 1'b0);
    poke(1, 1'b0);
    m_on = 0;
    m_rdone = 1;
    check_pins();
    cmd_wr(0, 4, 1, 1, 1, 4'h1);
    check_pins();
    // resume only takes effect together with the write order bit
    ahb(1'b1, 8'h08, 32'h9);
    m_halt = 0;
    m_on = 1;
    check_pins();
    rd_chk();
    // unmapped host address reads zero
    seed = xs(seed);
    ahb(1'b1, 8'h10, seed);
    ahb(1'b0, 8'h10, 32'h0);
    chk_reg(r, 32'h0);
    final_report();
  end
endmodule
